/* rtl/bgp_gpio_port.sv */
// four-pin gpio port living in one configuration dword of the bridge
`timescale 1ns/10ps
`default_nettype none
module bgp_gpio_port
  import bgp_pkg::*;
#(
  parameter int PINS = 4
) (
  // clock, reset, clock enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // configuration access
  input wire bgp_cfg_req_s cfgReq,
  output var bgp_cfg_rsp_s cfgRsp,
  // gpio pins
  input wire logic [PINS-1:0] pinIn,
  output logic [PINS-1:0] pinOut,
  output logic [PINS-1:0] pinOe
);
  // field layout is fixed at four pins per nibble
  if (PINS != PIN_COUNT) begin : gBadPins
    $error("bgp_gpio_port supports exactly four pins");
  end

  logic [3:0] outLevel, next_outLevel;
  logic [3:0] drvEn, next_drvEn;
  logic [3:0] clrLast, next_clrLast;
  logic [3:0] setLast, next_setLast;
  logic [3:0] enClrLast, next_enClrLast;
  logic [3:0] enSetLast, next_enSetLast;
  logic [3:0] inField;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic addrHit, wrOut, wrEn;
  logic [3:0] wClr, wSet, wEnClr, wEnSet;

  // pins are sampled through two flops since they are asynchronous
  bgp_sync #(.WIDTH(4)) uSync (
    .mclk(mclk),
    .nrst(nrst),
    .ce(ce),
    .asyncIn(pinIn),
    .syncOut(inField)
  );

  // decode: dword match, then byte lanes select the register
  always_comb begin
    addrHit = (cfgReq.addr[7:2] == GPIO_DWORD_OFFSET[7:2]);
    wrOut = cfgReq.write && addrHit && !cfgReq.primaryCmdByteEnableN[LANE_OUT];
    wrEn = cfgReq.write && addrHit && !cfgReq.primaryCmdByteEnableN[LANE_EN];
    wClr = cfgReq.wdata[OUT_CLR_LSB +: 4];
    wSet = cfgReq.wdata[OUT_SET_LSB +: 4];
    wEnClr = cfgReq.wdata[EN_CLR_LSB +: 4];
    wEnSet = cfgReq.wdata[EN_SET_LSB +: 4];
  end

  // next state of levels, enables and last-written fields
  always_comb begin
    next_outLevel = outLevel;
    next_drvEn = drvEn;
    next_clrLast = clrLast;
    next_setLast = setLast;
    next_enClrLast = enClrLast;
    next_enSetLast = enSetLast;
    if (wrOut) begin
      // clear applied after set so low wins; zeros leave bits alone
      next_outLevel = (outLevel | wSet) & ~wClr;
      next_clrLast = wClr;
      next_setLast = wSet;
    end
    if (wrEn) begin
      // clear after set: a pin named in both ends up input only
      next_drvEn = (drvEn | wEnSet) & ~wEnClr;
      next_enClrLast = wEnClr;
      next_enSetLast = wEnSet;
    end
  end

  // read answer: whole dword, lane 0 belongs to another unit and reads zero
  always_comb begin
    next_rvalid = cfgReq.read;
    next_rdata = 32'h0000_0000;
    if (cfgReq.read && addrHit) begin
      next_rdata = {inField, RSVD_READ, enSetLast, enClrLast, setLast, clrLast, LANE0_READ};
    end
  end

  // state registers, frozen while ce is low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      outLevel <= FIELD_RESET;
      drvEn <= FIELD_RESET;
      clrLast <= FIELD_RESET;
      setLast <= FIELD_RESET;
      enClrLast <= FIELD_RESET;
      enSetLast <= FIELD_RESET;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      outLevel <= next_outLevel;
      drvEn <= next_drvEn;
      clrLast <= next_clrLast;
      setLast <= next_setLast;
      enClrLast <= next_enClrLast;
      enSetLast <= next_enSetLast;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
    end
  end

  // pins straight from flops, so a write shows on the next cycle
  assign pinOut = outLevel;
  assign pinOe = drvEn;
  assign cfgRsp.rvalid = rvalid;
  assign cfgRsp.rdata = rdata;

  // checks
  chk_clear_drives_low: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut) |=> ((pinOut & $past(wClr)) == 4'h0))
    else $error("output clear did not drive pin low");
  chk_set_drives_high: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut) |=> ((pinOut & ($past(wSet) & ~$past(wClr))) == ($past(wSet) & ~$past(wClr))))
    else $error("output set did not drive pin high");
  chk_input_not_driven: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && !wrEn && pinOe == 4'h0) |=> (pinOe == 4'h0))
    else $error("input only pin became driven");
  chk_zero_no_effect: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cfgReq.write && cfgReq.wdata == 32'h0000_0000) |=> ($stable(pinOut) && $stable(pinOe)))
    else $error("zero write changed pin state");
  chk_readback_last: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut) ##1 (ce && cfgReq.read && addrHit && !wrOut) |=> (rdata[OUT_SET_LSB +: 4] == $past(setLast)))
    else $error("set field read back wrong");
  chk_both_low_wins: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut && (wSet & wClr) != 4'h0) |=> ((pinOut & $past(wSet & wClr)) == 4'h0))
    else $error("set and clear together did not give low");
  chk_enclr_wins: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrEn) |=> ((pinOe & $past(wEnClr)) == 4'h0))
    else $error("enable clear did not tristate pin");
  chk_enset_drives: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrEn && (wEnSet & ~wEnClr) != 4'h0) |=> ((pinOe & $past(wEnSet & ~wEnClr)) == $past(wEnSet & ~wEnClr)))
    else $error("enable set did not drive pin");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!nrst)
    rvalid |-> (rdata[RSVD_LSB +: 4] == 4'h0 && rdata[7:0] == 8'h00))
    else $error("reserved bits read nonzero");
  chk_reset_inputs: assert property (@(posedge mclk)
    $rose(nrst) |-> (pinOe == 4'h0 && clrLast == 4'h0 && enSetLast == 4'h0))
    else $error("not all inputs after reset");

  // an enable-clear alone must let go of the pin
  chk_enclr_tristates: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrEn && wEnClr != 4'h0) |=> ((pinOe & $past(wEnClr)) == 4'h0))
    else $error("enable clear left pin driven");

  // clock enable low must freeze the pins, whatever the bus does
  chk_ce_freezes_pins: assert property (@(posedge mclk) disable iff (!nrst)
    (!ce) |=> ($stable(pinOut) && $stable(pinOe)))
    else $error("pins moved while clock enable low");

  // clock enable low must also freeze the read answer
  chk_ce_freezes_read: assert property (@(posedge mclk) disable iff (!nrst)
    (!ce) |=> ($stable(rvalid) && $stable(rdata)))
    else $error("read answer moved while clock enable low");

  // no output-data write, no change of level
  chk_idle_holds_level: assert property (@(posedge mclk) disable iff (!nrst)
    (!wrOut) |=> $stable(pinOut))
    else $error("pin level changed without a write");

  // drivers only switch on through an enable write
  chk_idle_holds_enable: assert property (@(posedge mclk) disable iff (!nrst)
    (!wrEn) |=> $stable(pinOe))
    else $error("pin enable changed without a write");

  // the new level is on the pin one cycle after the write is taken
  chk_write_lands_next: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut) |=> (pinOut == (($past(pinOut) | $past(wSet)) & ~$past(wClr))))
    else $error("pin level late or wrong after write");

  // output-data fields remember exactly what was written
  chk_readback_clear: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrOut) |=> (clrLast == $past(wClr) && setLast == $past(wSet)))
    else $error("output fields did not keep written value");

  // enable fields remember exactly what was written
  chk_readback_enable: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrEn) |=> (enClrLast == $past(wEnClr) && enSetLast == $past(wEnSet)))
    else $error("enable fields did not keep written value");

  // a hit read returns all four last-written fields
  chk_read_fields: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cfgReq.read && addrHit) |=> (rdata[OUT_CLR_LSB +: 16] == $past({enSetLast, enClrLast, setLast, clrLast})))
    else $error("read data fields wrong");

  // a hit read returns the sampled pin levels
  chk_input_field: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cfgReq.read && addrHit) |=> (rdata[IN_LSB +: 4] == $past(inField)))
    else $error("input field did not report pins");

  // every taken read is answered on the next cycle
  chk_rvalid_pulse: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cfgReq.read) |=> rvalid)
    else $error("read not answered");

  // no read, no answer: the valid lasts a single enabled cycle
  chk_rvalid_drops: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && !cfgReq.read) |=> !rvalid)
    else $error("answer without a read");

  // reads outside the dword give zero
  chk_unmapped_zero: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && cfgReq.read && !addrHit) |=> (rdata == 32'h0000_0000))
    else $error("unmapped read nonzero");

  // lane 1 disabled: output data untouched
  chk_lane_gate_out: assert property (@(posedge mclk) disable iff (!nrst)
    (cfgReq.write && cfgReq.primaryCmdByteEnableN[LANE_OUT]) |=> ($stable(pinOut) && $stable(setLast) && $stable(clrLast)))
    else $error("output data written without its lane");

  // lane 2 disabled: output enable untouched
  chk_lane_gate_en: assert property (@(posedge mclk) disable iff (!nrst)
    (cfgReq.write && cfgReq.primaryCmdByteEnableN[LANE_EN]) |=> ($stable(pinOe) && $stable(enSetLast) && $stable(enClrLast)))
    else $error("output enable written without its lane");

  // the rest of the state also starts from zero
  chk_reset_level: assert property (@(posedge mclk)
    $rose(nrst) |-> (pinOut == 4'h0 && setLast == 4'h0 && enClrLast == 4'h0 && rvalid == 1'b0))
    else $error("state not zero after reset");
endmodule
`default_nettype wire

/* rtl/bgp_pkg.sv */
// package for the bridge gpio port: offsets, field positions, reset values and carriers
// How it works
// - a one in the output-clear field drives that pin low when bidirectional
// - a one in the output-set field drives that pin high when bidirectional
// - new pin level appears in the cycle after the write is taken
// - input-only pins are never driven, whatever set or clear writes arrive
// - zero bits in any set or clear field change nothing
// - set and clear fields read back the last value written to them
// - set and clear together for one pin: the pin goes low
// - a one in the enable-clear field makes that pin input only
// - a one in the enable-set field turns the driver on with the held level
// - enable-set and enable-clear together for one pin: the pin is input only
// - after reset all set and clear fields read zero and every pin is input only
// - the input field reports the pin levels, refreshed every cycle that ce is high
// - the reserved nibble under the input field always reads zero
// - one dword holds output data, enable and input in byte lanes 1, 2, 3
package bgp_pkg;
  localparam int PIN_COUNT = 4;
  localparam logic [7:0] GPIO_DWORD_OFFSET = 8'h64;
  // field positions inside the dword
  localparam int OUT_CLR_LSB = 8;
  localparam int OUT_SET_LSB = 12;
  localparam int EN_CLR_LSB = 16;
  localparam int EN_SET_LSB = 20;
  localparam int RSVD_LSB = 24;
  localparam int IN_LSB = 28;
  // byte lanes of each register
  localparam int LANE_OUT = 1;
  localparam int LANE_EN = 2;
  // reset value of the fields, fixed read values of lane 0 and the reserved nibble
  localparam logic [3:0] FIELD_RESET = 4'h0;
  localparam logic [7:0] LANE0_READ = 8'h00;
  localparam logic [3:0] RSVD_READ = 4'h0;

  // one configuration access, byte enables active low as on the bus
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [3:0] primaryCmdByteEnableN;
    logic [31:0] wdata;
  } bgp_cfg_req_s;

  typedef struct packed {
    logic rvalid;
    logic [31:0] rdata;
  } bgp_cfg_rsp_s;
endpackage

/* rtl/bgp_sync.sv */
// two-flop synchroniser for the gpio input pins
`timescale 1ns/10ps
`default_nettype none
module bgp_sync #(
  parameter int WIDTH = 4
) (
  // clock, reset and clock enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // async in, synchronous out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      syncOut <= '0;
    end else if (ce) begin
      meta <= asyncIn;
      syncOut <= meta;
    end
  end
endmodule
`default_nettype wire

/* test/bgp_pin_model.sv */
// far-side model: external circuitry on the four gpio pins
`timescale 1ns/10ps
`default_nettype none
module bgp_pin_model (
  // device side of the pins
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  // level the outside world drives
  input wire logic [3:0] extLevel,
  output logic [3:0] pinWire
);
  // outside drive wins only where the port has let go
  assign pinWire = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule
`default_nettype wire

/* test/tb_bridge_gpio_port.sv */
// self-checking bench for the bridge gpio port
`timescale 1ns/10ps
`default_nettype none
module tb_bridge_gpio_port;
  import bgp_pkg::*;
  logic mclk, nrst, ce;
  bgp_cfg_req_s cfgReq;
  bgp_cfg_rsp_s cfgRsp;
  logic [3:0] pinOut, pinOe, pinWire, extLevel, lvl, oe;
  logic [15:0] lfsr, lastW;
  int miscompares, checks_done;
  bgp_gpio_port #(.PINS(4)) uut (.mclk(mclk), .nrst(nrst), .ce(ce), .cfgReq(cfgReq), .cfgRsp(cfgRsp),
    .pinIn(pinWire), .pinOut(pinOut), .pinOe(pinOe));
  bgp_pin_model pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinWire(pinWire));
  // free-running bus clock
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // whole dword expected; lane 0 and unmapped places read zero
  function automatic logic [31:0] exp_read(input logic [7:0] a);
    return (a[7:2] == GPIO_DWORD_OFFSET[7:2]) ? {pinWire, RSVD_READ, lastW, LANE0_READ} : 32'h0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one-cycle write strobe, then pins must follow on the next cycle
  task automatic cfg_write(input logic [7:0] a, input logic [3:0] ben, input logic [31:0] d);
    @(posedge mclk);
    cfgReq <= '{1'b1, 1'b0, a, ben, d};
    @(posedge mclk);
    cfgReq.write <= 1'b0;
    if (a[7:2] == GPIO_DWORD_OFFSET[7:2] && !ben[LANE_OUT]) begin
      lastW[7:0] = d[15:8];
      lvl = (lvl | d[15:12]) & ~d[11:8];
    end
    if (a[7:2] == GPIO_DWORD_OFFSET[7:2] && !ben[LANE_EN]) begin
      lastW[15:8] = d[23:16];
      oe = (oe | d[23:20]) & ~d[19:16];
    end
    #1;
    check({24'h0, pinOut, pinOe}, {24'h0, lvl, oe});
  endtask
  // settle the two-flop pin sampler first, then read with a bounded wait
  task automatic cfg_read(input logic [7:0] a);
    int n;
    repeat (3) @(posedge mclk);
    cfgReq <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
    @(posedge mclk);
    cfgReq.read <= 1'b0;
    n = 0;
    #1;
    while (cfgRsp.rvalid !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 8) begin
      miscompares++;
      finish_test();
    end
    check(cfgRsp.rdata, exp_read(a));
  endtask
  // watchdog against a hung run
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    extLevel = 4'hA;
    lfsr = 16'd28;
    lvl = 4'h0;
    oe = 4'h0;
    lastW = 16'h0;
    cfgReq = '0;
    miscompares = 0;
    checks_done = 0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    cfg_read(8'h64);
    cfg_write(8'h64, 4'h9, 32'h00FF_FF00);
    cfg_read(8'h64);
    cfg_write(8'h64, 4'hB, 32'h00F0_0000);
    cfg_write(8'h64, 4'hD, 32'h0000_5A00);
    cfg_write(8'h64, 4'h9, 32'h0000_0000);
    // clock enable low: a write must leave the pins alone
    @(posedge mclk);
    ce <= 1'b0;
    cfgReq <= '{1'b1, 1'b0, 8'h64, 4'h9, 32'h000F_0F00};
    @(posedge mclk);
    cfgReq.write <= 1'b0;
    ce <= 1'b1;
    #1;
    check({24'h0, pinOut, pinOe}, {24'h0, lvl, oe});
    cfg_read(8'h68);
    // random traffic: lanes, addresses and outside levels all vary
    for (int i = 0; i < 200; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge mclk);
      extLevel <= lfsr[3:0];
      cfg_write(lfsr[7] ? 8'h64 : 8'h6C, lfsr[15:12], {lfsr, lfsr_next(lfsr)});
      if (lfsr[0]) cfg_read(lfsr[9] ? 8'h67 : 8'h60);
    end
    finish_test();
  end
endmodule
`default_nettype wire
